// ### verilog/fsrc_pkg.sv
package fsrc_pkg;

  // ---------------------------------------------------------------
  // Register map (word index equals address on the plain port)
  // ---------------------------------------------------------------
  localparam int ADDR_W = 4;
  localparam logic [3:0] REG_CTRL_A = 4'h0;
  localparam logic [3:0] REG_CTRL_D = 4'h1;
  localparam logic [3:0] REG_ID_STAT = 4'h2;
  localparam logic [3:0] REG_PROC_MODE = 4'h3;
  localparam logic [3:0] REG_CMD = 4'h4;
  localparam logic [3:0] REG_CMD_ADDR = 4'h5;
  localparam logic [3:0] REG_CODE_BLK = 4'h6;
  localparam logic [3:0] REG_STATUS = 4'h7;

  // ---------------------------------------------------------------
  // Field positions
  // ---------------------------------------------------------------
  localparam int CA_READY = 0;
  localparam int CA_REWRITE_EN = 1;
  localparam int CA_PROG_ERR = 6;
  localparam int CA_ERASE_ERR = 7;
  localparam int CD_MODE_SEL = 0;
  localparam int PM_EXT_AREA = 0;
  localparam int PM_INT_RSV = 3;
  localparam int SR_PROG_ERR = 4;
  localparam int SR_ERASE_ERR = 5;
  localparam int SR_READY = 7;
  localparam int IS_MATCH = 0;
  localparam int IS_REJECT = 1;
  localparam int IS_ERASING = 2;
  localparam int IS_SILENT = 3;
  localparam int IS_CPU_STALL = 4;
  localparam int IS_ARRAY_READ = 5;
  localparam int IS_STATUS_READ = 6;

  // ---------------------------------------------------------------
  // Commands and reserved words
  // ---------------------------------------------------------------
  localparam logic [7:0] CMD_PROGRAM = 8'h40;
  localparam logic [7:0] CMD_BLOCK_ERASE = 8'h20;
  localparam logic [7:0] CMD_READ_STATUS = 8'h70;
  localparam logic [7:0] CMD_CLEAR_STATUS = 8'h50;
  localparam logic [7:0] CMD_LOCK_PROG = 8'h77;
  localparam logic [7:0] CMD_LOCK_READ = 8'h71;
  localparam logic [7:0] CMD_BLANK_CHECK = 8'h25;
  localparam logic [55:0] FORCED_ERASE_WORD = 56'h414c6552415345;
  localparam logic [55:0] SERIAL_DISABLE_WORD = 56'h50726f74656374;
  localparam int ID_BYTES = 7;

  // ---------------------------------------------------------------
  // Flash regions (byte addresses)
  // ---------------------------------------------------------------
  localparam logic [23:0] PROM1_LO = 24'h0c0000;
  localparam logic [23:0] PROM1_HI = 24'h0fffff;
  localparam logic [23:0] PROM2_LO = 24'h010000;
  localparam logic [23:0] PROM2_HI = 24'h013fff;
  localparam logic [23:0] DFLASH_LO = 24'h00e000;
  localparam logic [23:0] DFLASH_HI = 24'h00ffff;
  localparam logic [23:0] EXT_LO = 24'h040000;
  localparam logic [23:0] EXT_HI = 24'h0bffff;
  localparam int BLK_SHIFT = 12;

  localparam real CLK_NS = 10.0;
  localparam real OP_TIME_NS = 1000.0;
  localparam int OP_CYCLES = int'(OP_TIME_NS / CLK_NS);
  localparam int ID_STEP = 3;

  typedef enum logic [1:0] {FSRC_OP_IDLE, FSRC_OP_BUSY} fsrc_op_t;
  typedef enum logic [1:0] {FSRC_ID_WAIT, FSRC_ID_OK, FSRC_ID_REJECT, FSRC_ID_ERASE} fsrc_id_t;

endpackage : fsrc_pkg

// ### verilog/fsrc_id_check.sv
`timescale 1ns/1ns
module fsrc_id_check (
  input wire logic ref_clk_i,
  input wire logic reset_i,
  input wire logic serial_mode_i,
  input wire logic id_valid_i,
  input wire logic [7:0] id_byte_i,
  input wire logic [55:0] stored_id_i,
  input wire logic rom_protect_bit_i,
  output logic done_o,
  output logic match_o,
  output logic reject_o,
  output logic erase_o
);
  import fsrc_pkg::*;

  // ---------------------------------------------------------------
  // Byte collection
  // ---------------------------------------------------------------
  logic [55:0] rx_r, rx_nxt;
  logic [2:0] cnt_r, cnt_nxt;
  fsrc_id_t st_r, st_nxt;
  logic rx_forced, st_forced, st_silent;
  logic [55:0] rx_shift;

  assign rx_shift = {rx_r[47:0], id_byte_i};
  assign rx_forced = (rx_shift == FORCED_ERASE_WORD);
  assign st_forced = (stored_id_i == FORCED_ERASE_WORD);
  assign st_silent = (stored_id_i == SERIAL_DISABLE_WORD);

  always_comb begin
    rx_nxt = rx_r;
    cnt_nxt = cnt_r;
    st_nxt = st_r;
    if (st_r == FSRC_ID_WAIT && serial_mode_i && !st_silent && id_valid_i) begin
      rx_nxt = rx_shift;
      cnt_nxt = cnt_r + 3'h1;
      if (cnt_r == 3'(ID_BYTES - 1)) begin
        if (rx_forced && (st_forced || rom_protect_bit_i)) begin
          st_nxt = FSRC_ID_ERASE;
        end else if (rx_shift == stored_id_i && !st_forced) begin
          st_nxt = FSRC_ID_OK;
        end else begin
          st_nxt = FSRC_ID_REJECT;
        end
      end
    end
  end

  always_ff @(posedge ref_clk_i or posedge reset_i) begin
    if (reset_i) begin
      rx_r <= 56'h0;
      cnt_r <= 3'h0;
      st_r <= FSRC_ID_WAIT;
    end else begin
      rx_r <= rx_nxt;
      cnt_r <= cnt_nxt;
      st_r <= st_nxt;
    end
  end

  assign done_o = (st_r != FSRC_ID_WAIT);
  assign match_o = (st_r == FSRC_ID_OK);
  assign reject_o = (st_r == FSRC_ID_REJECT);
  assign erase_o = (st_r == FSRC_ID_ERASE);

endmodule : fsrc_id_check

// ### verilog/fsrc_ctrl.sv
// The plain strobed port and the register addresses were left to the implementer.
`timescale 1ns/1ns
// Behaviour
// - Forced erase only in serial programming mode
// - Both IDs forced word: erase whole ROM
// - Stored differs: erase only if unprotected
// - Stored forced, other sent: reject all
// - Serial-disable word: no serial communication
// - Serial-disable word still permits user boot
// - Disable word plus protect: never unprotect
// - Program/erase only inside flash block regions
// - Rewrite enable set starts command acceptance
// - Mode select zero means RAM-resident mode
// - Completion: status-read or array-read state
// - Flash-resident mode stalls CPU during operation
// - Flash-resident mode: no status read
// - Flash-resident: refuse code-holding block
// - RAM-resident: status register with three bits
// - Rewrite mode forces two processor bits
// - Reserved select zero blocks extended region in 4 MB mode
// - Flash-resident: hold port outputs during operation
// - Ready flag low while command executes
// - Error flags set on program/erase error
module fsrc_ctrl #(
  parameter int OP_CNT = fsrc_pkg::OP_CYCLES,
  parameter int PORT_W = 8
) (
  input wire logic ref_clk_i,
  input wire logic reset_i,
  input wire logic [fsrc_pkg::ADDR_W-1:0] addr_i,
  input wire logic [31:0] wdata_i,
  input wire logic wr_i,
  input wire logic rd_i,
  output logic [31:0] rdata_o,
  input wire logic serial_mode_i,
  input wire logic boot_user_sel_i,
  input wire logic id_valid_i,
  input wire logic [7:0] id_byte_i,
  input wire logic [55:0] stored_id_i,
  input wire logic rom_protect_bit_i,
  input wire logic unprotect_req_i,
  input wire logic serial_cmd_i,
  input wire logic op_fail_i,
  input wire logic four_mb_mode_i,
  input wire logic [PORT_W-1:0] port_i,
  output logic [PORT_W-1:0] port_o,
  output logic serial_accept_o,
  output logic serial_erase_all_o,
  output logic user_boot_o,
  output logic rom_protected_o,
  output logic cpu_stall_o,
  output logic ext_region_block_o
);
  import fsrc_pkg::*;

  // ---------------------------------------------------------------
  // Serial ID check
  // ---------------------------------------------------------------
  logic id_done, id_match, id_reject, id_erase;
  logic silent;

  fsrc_id_check u_id (
    .ref_clk_i(ref_clk_i),
    .reset_i(reset_i),
    .serial_mode_i(serial_mode_i),
    .id_valid_i(id_valid_i),
    .id_byte_i(id_byte_i),
    .stored_id_i(stored_id_i),
    .rom_protect_bit_i(rom_protect_bit_i),
    .done_o(id_done),
    .match_o(id_match),
    .reject_o(id_reject),
    .erase_o(id_erase)
  );

  assign silent = (stored_id_i == SERIAL_DISABLE_WORD);

  // ---------------------------------------------------------------
  // Control state
  // ---------------------------------------------------------------
  logic rw_en_r, rw_en_nxt;
  logic mode_r, mode_nxt;
  logic pgm_err_r, pgm_err_nxt;
  logic ers_err_r, ers_err_nxt;
  logic [23:0] cmd_addr_r, cmd_addr_nxt;
  logic [23:0] code_addr_r, code_addr_nxt;
  logic [7:0] pm_r, pm_nxt;
  logic is_erase_r, is_erase_nxt;
  logic stat_mode_r, stat_mode_nxt;
  logic [31:0] cnt_r, cnt_nxt;
  fsrc_op_t op_r, op_nxt;
  logic [PORT_W-1:0] port_r, port_nxt;
  logic [31:0] rdata_r, rdata_nxt;
  logic accept_r, accept_nxt;
  logic erase_all_r, erase_all_nxt;
  logic boot_r, boot_nxt;
  logic prot_r, prot_nxt;
  logic stall_r, stall_nxt;
  logic ext_blk_r, ext_blk_nxt;

  logic in_region, own_block, cmd_wr, ew1, busy, done_pulse, cmd_ok;
  logic [7:0] cmd;
  logic [31:0] ca_word, sr_word, is_word;

  assign cmd_wr = wr_i && addr_i == REG_CMD;
  assign cmd = wdata_i[7:0];
  assign ew1 = rw_en_r && mode_r;
  assign busy = (op_r == FSRC_OP_BUSY);
  assign done_pulse = busy && cnt_r == 32'h1;

  // ---------------------------------------------------------------
  // Rewritable regions
  // ---------------------------------------------------------------
  localparam int N_REGION = 3;
  localparam logic [23:0] REGION_LO [N_REGION] = '{PROM1_LO, PROM2_LO, DFLASH_LO};
  localparam logic [23:0] REGION_HI [N_REGION] = '{PROM1_HI, PROM2_HI, DFLASH_HI};
  logic [N_REGION-1:0] region_hit;

  // Regions checked on the latched target address
  for (genvar g = 0; g < N_REGION; g++) begin : g_region
    assign region_hit[g] = (cmd_addr_r >= REGION_LO[g]) && (cmd_addr_r <= REGION_HI[g]);
  end
  assign in_region = |region_hit;
  assign own_block = (cmd_addr_r[23:BLK_SHIFT] == code_addr_r[23:BLK_SHIFT]);
  assign cmd_ok = in_region && !(ew1 && own_block);

  // ---------------------------------------------------------------
  // Next-state logic
  // ---------------------------------------------------------------
  always_comb begin
    rw_en_nxt = rw_en_r;
    mode_nxt = mode_r;
    pgm_err_nxt = pgm_err_r;
    ers_err_nxt = ers_err_r;
    cmd_addr_nxt = cmd_addr_r;
    code_addr_nxt = code_addr_r;
    pm_nxt = pm_r;
    is_erase_nxt = is_erase_r;
    stat_mode_nxt = stat_mode_r;
    cnt_nxt = cnt_r;
    op_nxt = op_r;
    port_nxt = port_r;
    if (wr_i && !busy) begin
      unique case (addr_i)
        REG_CTRL_A: begin
          rw_en_nxt = wdata_i[CA_REWRITE_EN];
          // Dropping the enable also leaves flash-resident mode
          if (!wdata_i[CA_REWRITE_EN]) begin
            mode_nxt = 1'b0;
          end
        end
        // Mode select only takes once rewrite is already on
        REG_CTRL_D: mode_nxt = rw_en_r & wdata_i[CD_MODE_SEL];
        REG_PROC_MODE: pm_nxt = wdata_i[7:0];
        REG_CMD_ADDR: cmd_addr_nxt = wdata_i[23:0];
        REG_CODE_BLK: code_addr_nxt = wdata_i[23:0];
        default: ;
      endcase
    end
    if (rw_en_r) begin
      pm_nxt[PM_EXT_AREA] = 1'b1;
      pm_nxt[PM_INT_RSV] = 1'b1;
    end
    // Command port is dead until rewrite mode is on
    if (cmd_wr && rw_en_r && !busy) begin
      unique case (cmd)
        // A refused target starts nothing, it only raises the error flag
        CMD_PROGRAM, CMD_BLOCK_ERASE: begin
          if (cmd_ok) begin
            op_nxt = FSRC_OP_BUSY;
            cnt_nxt = 32'(OP_CNT);
            is_erase_nxt = (cmd == CMD_BLOCK_ERASE);
            port_nxt = port_i;
          end else if (cmd == CMD_BLOCK_ERASE) begin
            ers_err_nxt = 1'b1;
          end else begin
            pgm_err_nxt = 1'b1;
          end
        end
        CMD_LOCK_PROG, CMD_LOCK_READ, CMD_BLANK_CHECK: begin
          op_nxt = FSRC_OP_BUSY;
          cnt_nxt = 32'(OP_CNT);
          is_erase_nxt = 1'b0;
          port_nxt = port_i;
        end
        CMD_READ_STATUS: stat_mode_nxt = !ew1;
        CMD_CLEAR_STATUS: begin
          pgm_err_nxt = 1'b0;
          ers_err_nxt = 1'b0;
        end
        default: stat_mode_nxt = 1'b0;
      endcase
    end
    if (busy) begin
      cnt_nxt = cnt_r - 32'h1;
      if (done_pulse) begin
        op_nxt = FSRC_OP_IDLE;
        stat_mode_nxt = !ew1;
        // Failure is sampled on the last busy cycle only
        if (op_fail_i && is_erase_r) begin
          ers_err_nxt = 1'b1;
        end
        if (op_fail_i && !is_erase_r) begin
          pgm_err_nxt = 1'b1;
        end
      end
    end
    // Ports track the pins except while a flash-resident operation runs
    if (!ew1) begin
      port_nxt = port_i;
    end else if (!busy && !(cmd_wr && rw_en_r)) begin
      port_nxt = port_i;
    end
  end

  // ---------------------------------------------------------------
  // Read path and pin outputs
  // ---------------------------------------------------------------
  always_comb begin
    ca_word = 32'h0;
    ca_word[CA_READY] = !busy;
    ca_word[CA_REWRITE_EN] = rw_en_r;
    ca_word[CA_PROG_ERR] = pgm_err_r;
    ca_word[CA_ERASE_ERR] = ers_err_r;
    sr_word = 32'h0;
    if (!ew1) begin
      sr_word[SR_READY] = !busy;
      sr_word[SR_ERASE_ERR] = ers_err_r;
      sr_word[SR_PROG_ERR] = pgm_err_r;
    end
    is_word = 32'h0;
    is_word[IS_MATCH] = id_match;
    is_word[IS_REJECT] = id_reject;
    is_word[IS_ERASING] = id_erase;
    is_word[IS_SILENT] = silent;
    is_word[IS_CPU_STALL] = stall_r;
    is_word[IS_ARRAY_READ] = !stat_mode_r;
    is_word[IS_STATUS_READ] = stat_mode_r;
    rdata_nxt = 32'h0;
    if (rd_i) begin
      unique case (addr_i)
        REG_CTRL_A: rdata_nxt = ca_word;
        REG_CTRL_D: rdata_nxt = {31'h0, mode_r};
        REG_ID_STAT: rdata_nxt = is_word;
        REG_PROC_MODE: rdata_nxt = {24'h0, pm_r};
        REG_CMD_ADDR: rdata_nxt = {8'h0, cmd_addr_r};
        REG_CODE_BLK: rdata_nxt = {8'h0, code_addr_r};
        REG_STATUS: rdata_nxt = sr_word;
        default: rdata_nxt = 32'h0;
      endcase
    end
    // Serial path never answers with the disable word stored
    accept_nxt = id_match && serial_mode_i && !silent && serial_cmd_i;
    erase_all_nxt = id_erase && serial_mode_i;
    boot_nxt = boot_user_sel_i;
    prot_nxt = !id_match || (silent && !rom_protect_bit_i) || !rom_protect_bit_i;
    if (silent && !rom_protect_bit_i && unprotect_req_i) begin
      prot_nxt = 1'b1;
    end
    stall_nxt = ew1 && (op_nxt == FSRC_OP_BUSY);
    // Rewrite mode forces the reserved select, so this bites outside it
    ext_blk_nxt = !pm_nxt[PM_INT_RSV] && four_mb_mode_i;
  end

  // ---------------------------------------------------------------
  // Control registers
  // ---------------------------------------------------------------
  always_ff @(posedge ref_clk_i or posedge reset_i) begin
    if (reset_i) begin
      rw_en_r <= 1'b0;
      mode_r <= 1'b0;
      pgm_err_r <= 1'b0;
      ers_err_r <= 1'b0;
      cmd_addr_r <= 24'h0;
      code_addr_r <= 24'h0;
      pm_r <= 8'h0;
    end else begin
      rw_en_r <= rw_en_nxt;
      mode_r <= mode_nxt;
      pgm_err_r <= pgm_err_nxt;
      ers_err_r <= ers_err_nxt;
      cmd_addr_r <= cmd_addr_nxt;
      code_addr_r <= code_addr_nxt;
      pm_r <= pm_nxt;
    end
  end

  // ---------------------------------------------------------------
  // Operation registers
  // ---------------------------------------------------------------
  always_ff @(posedge ref_clk_i or posedge reset_i) begin
    if (reset_i) begin
      is_erase_r <= 1'b0;
      stat_mode_r <= 1'b0;
      cnt_r <= 32'h0;
      op_r <= FSRC_OP_IDLE;
      port_r <= '0;
    end else begin
      is_erase_r <= is_erase_nxt;
      stat_mode_r <= stat_mode_nxt;
      cnt_r <= cnt_nxt;
      op_r <= op_nxt;
      port_r <= port_nxt;
    end
  end

  // ---------------------------------------------------------------
  // Output registers
  // ---------------------------------------------------------------
  // Every pin leaves straight from a flop, so read data costs one cycle
  always_ff @(posedge ref_clk_i or posedge reset_i) begin
    if (reset_i) begin
      rdata_r <= 32'h0;
      accept_r <= 1'b0;
      erase_all_r <= 1'b0;
      boot_r <= 1'b0;
      prot_r <= 1'b1;
      stall_r <= 1'b0;
      ext_blk_r <= 1'b0;
    end else begin
      rdata_r <= rdata_nxt;
      accept_r <= accept_nxt;
      erase_all_r <= erase_all_nxt;
      boot_r <= boot_nxt;
      prot_r <= prot_nxt;
      stall_r <= stall_nxt;
      ext_blk_r <= ext_blk_nxt;
    end
  end

  assign rdata_o = rdata_r;
  assign port_o = port_r;
  assign serial_accept_o = accept_r;
  assign serial_erase_all_o = erase_all_r;
  assign user_boot_o = boot_r;
  assign rom_protected_o = prot_r;
  assign cpu_stall_o = stall_r;
  assign ext_region_block_o = ext_blk_r;

endmodule : fsrc_ctrl

// ### bench/fsrc_ctrl_asserts.sv
`timescale 1ns/1ns
// ---------------------------------------------------------------
// Port checks
// ---------------------------------------------------------------
module fsrc_ctrl_asserts
  import fsrc_pkg::*;
#(
  parameter int PORT_W = 8
) (
  input wire logic ref_clk_i,
  input wire logic reset_i,
  input wire logic serial_mode_i,
  input wire logic boot_user_sel_i,
  input wire logic serial_cmd_i,
  input wire logic [55:0] stored_id_i,
  input wire logic rom_protect_bit_i,
  input wire logic four_mb_mode_i,
  input wire logic [PORT_W-1:0] port_o,
  input wire logic serial_accept_o,
  input wire logic serial_erase_all_o,
  input wire logic user_boot_o,
  input wire logic rom_protected_o,
  input wire logic cpu_stall_o,
  input wire logic ext_region_block_o
);
  default clocking cb @(posedge ref_clk_i); endclocking
  default disable iff (reset_i);
  a_accept_after_cmd: assert property (serial_accept_o |-> $past(serial_cmd_i))
    else $error("accept without a command");
  a_erase_serial_only: assert property ($rose(serial_erase_all_o) |-> $past(serial_mode_i))
    else $error("forced erase outside serial mode");
  a_erase_held: assert property (serial_erase_all_o |=> serial_erase_all_o)
    else $error("forced erase dropped");
  a_silent_tool: assert property ($past(stored_id_i) == SERIAL_DISABLE_WORD |-> !serial_accept_o)
    else $error("accepted with serial disabled");
  a_boot_follows: assert property (!$past(reset_i) |-> user_boot_o == $past(boot_user_sel_i))
    else $error("user boot not following selection");
  a_protect_kept: assert property (
    $past(stored_id_i) == SERIAL_DISABLE_WORD && !$past(rom_protect_bit_i) |-> rom_protected_o)
    else $error("protection lifted");
  // Bound fits OP_CNT of four used in the bench
  a_stall_span: assert property ($rose(cpu_stall_o) |-> cpu_stall_o[*3] ##[1:3] !cpu_stall_o)
    else $error("stall length wrong");
  a_ports_frozen: assert property (cpu_stall_o && $past(cpu_stall_o) |-> $stable(port_o))
    else $error("port moved during stall");
  a_ext_needs_4mb: assert property (ext_region_block_o |-> $past(four_mb_mode_i))
    else $error("extended block without 4 MB mode");
endmodule : fsrc_ctrl_asserts

// ### bench/fsrc_tool.sv
`timescale 1ns/1ns
// ---------------------------------------------------------------
// Serial programming tool model
// ---------------------------------------------------------------
module fsrc_tool (
  input wire logic ref_clk_i,
  output logic id_valid_o,
  output logic [7:0] id_byte_o,
  output logic cmd_o
);
  initial begin
    id_valid_o = 1'b0;
    id_byte_o = 8'h00;
    cmd_o = 1'b0;
  end
  // First byte first; line shows inverse between bytes, never a stale byte
  task automatic send_id(input logic [55:0] id, input int gap);
    for (int i = 6; i >= 0; i--) begin
      @(posedge ref_clk_i);
      id_valid_o <= 1'b1;
      id_byte_o <= id[i*8 +: 8];
      @(posedge ref_clk_i);
      id_valid_o <= 1'b0;
      id_byte_o <= ~id[i*8 +: 8];
      repeat (gap) @(posedge ref_clk_i);
    end
  endtask : send_id
  task automatic send_cmd;
    @(posedge ref_clk_i);
    cmd_o <= 1'b1;
    @(posedge ref_clk_i);
    cmd_o <= 1'b0;
  endtask : send_cmd
endmodule : fsrc_tool

// ### bench/testbench.sv
`timescale 1ns/1ns
module testbench;
  import fsrc_pkg::*;
  localparam logic [55:0] OTHER_ID = 56'h11223344556677;
  logic ref_clk_i = 1'b0;
  logic reset_i = 1'b1;
  logic [3:0] addr_i = 4'h0;
  logic [31:0] wdata_i = 32'h0;
  logic wr_i = 1'b0;
  logic rd_i = 1'b0;
  logic serial_mode_i = 1'b0;
  logic boot_user_sel_i = 1'b0;
  logic [55:0] stored_id_i = 56'h0;
  logic rom_protect_bit_i = 1'b1;
  logic unprotect_req_i = 1'b0;
  logic op_fail_i = 1'b0;
  logic four_mb_mode_i = 1'b0;
  logic [7:0] port_i = 8'h00;
  logic id_valid_i, serial_cmd_i;
  logic [7:0] id_byte_i, port_o;
  logic [31:0] rdata_o, rv;
  logic serial_accept_o, serial_erase_all_o, user_boot_o, rom_protected_o, cpu_stall_o, ext_region_block_o;
  logic [7:0] cmds [5];
  int n_errors = 0;
  int n_tests = 0;

  fsrc_ctrl #(.OP_CNT(4), .PORT_W(8)) dut (.*);
  fsrc_tool tool (.ref_clk_i(ref_clk_i), .id_valid_o(id_valid_i), .id_byte_o(id_byte_i), .cmd_o(serial_cmd_i));

  always #5 ref_clk_i = ~ref_clk_i;

  // ---------------------------------------------------------------
  // Tasks
  // ---------------------------------------------------------------
  task automatic tally_and_finish;
    $display("comparisons %0d mismatches %0d", n_tests, n_errors);
    if (n_errors == 0 && n_tests > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask : tally_and_finish
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    n_tests++;
    if (seen !== exp) begin
      n_errors++;
      $display("[ERR] %0t seen %h expected %h", $time, seen, exp);
    end
  endtask : chk
  task automatic wr(input logic [3:0] a, input logic [31:0] d);
    @(posedge ref_clk_i);
    wr_i <= 1'b1;
    addr_i <= a;
    wdata_i <= d;
    @(posedge ref_clk_i);
    wr_i <= 1'b0;
  endtask : wr
  task automatic rc(input logic [3:0] a, input logic [31:0] m, input logic [31:0] e);
    @(posedge ref_clk_i);
    rd_i <= 1'b1;
    addr_i <= a;
    @(posedge ref_clk_i);
    rd_i <= 1'b0;
    #1 rv = rdata_o;
    chk(rv & m, e);
  endtask : rc
  task automatic do_reset;
    @(posedge ref_clk_i);
    reset_i <= 1'b1;
    repeat (4) @(posedge ref_clk_i);
    reset_i <= 1'b0;
  endtask : do_reset
  // Polls ready; a hang counts as a mismatch
  task automatic wait_ready;
    for (int i = 0; i < 20; i++) begin
      rc(REG_CTRL_A, 32'h0, 32'h0);
      if (rv[CA_READY] === 1'b1) return;
    end
    n_errors++;
    $display("[ERR] %0t ready timeout", $time);
    tally_and_finish();
  endtask : wait_ready
  task automatic run(input logic [23:0] a, input logic [7:0] c);
    wr(REG_CMD_ADDR, {8'h00, a});
    wr(REG_CMD, {24'h0, c});
  endtask : run
  task automatic id_case(input logic sm, input logic [55:0] st, input logic [55:0] sent, input logic pb,
                         input logic ca, input logic acc, input logic ers);
    serial_mode_i <= sm;
    stored_id_i <= st;
    rom_protect_bit_i <= pb;
    do_reset();
    tool.send_id(sent, ID_STEP);
    repeat (3) @(posedge ref_clk_i);
    tool.send_cmd();
    #1 if (ca) chk(serial_accept_o, acc);
    chk(serial_erase_all_o, ers);
    chk(rom_protected_o, !(acc && pb));
    tool.send_id(st, 0);
    tool.send_cmd();
    #1 if (ca) chk(serial_accept_o, acc);
  endtask : id_case

  // ---------------------------------------------------------------
  // Main sequence
  // ---------------------------------------------------------------
  initial begin
    do_reset();
    #1 chk(rom_protected_o, 1'b1);
    rc(REG_CTRL_A, 32'h3, 32'h1);
    id_case(1'b1, FORCED_ERASE_WORD, FORCED_ERASE_WORD, 1'b0, 1'b0, 1'b0, 1'b1);
    id_case(1'b1, OTHER_ID, FORCED_ERASE_WORD, 1'b1, 1'b0, 1'b0, 1'b1);
    id_case(1'b1, OTHER_ID, FORCED_ERASE_WORD, 1'b0, 1'b1, 1'b0, 1'b0);
    id_case(1'b1, FORCED_ERASE_WORD, OTHER_ID, 1'b0, 1'b1, 1'b0, 1'b0);
    id_case(1'b0, FORCED_ERASE_WORD, FORCED_ERASE_WORD, 1'b1, 1'b0, 1'b0, 1'b0);
    id_case(1'b1, OTHER_ID, OTHER_ID, 1'b1, 1'b1, 1'b1, 1'b0);
    id_case(1'b1, SERIAL_DISABLE_WORD, SERIAL_DISABLE_WORD, 1'b0, 1'b1, 1'b0, 1'b0);
    unprotect_req_i <= 1'b1;
    boot_user_sel_i <= 1'b1;
    repeat (2) @(posedge ref_clk_i);
    #1 chk(rom_protected_o, 1'b1);
    chk(user_boot_o, 1'b1);
    $display("id check test done");
    serial_mode_i <= 1'b0;
    stored_id_i <= OTHER_ID;
    unprotect_req_i <= 1'b0;
    do_reset();
    run(PROM1_LO, CMD_PROGRAM);
    rc(REG_CTRL_A, 32'h1, 32'h1);
    wr(REG_CTRL_D, 32'h1);
    rc(REG_CTRL_D, 32'h1, 32'h0);
    wr(REG_CTRL_A, 32'h2);
    wr(REG_CODE_BLK, 32'h400);
    rc(REG_PROC_MODE, 32'h9, 32'h9);
    cmds = '{CMD_PROGRAM, CMD_BLOCK_ERASE, CMD_LOCK_PROG, CMD_LOCK_READ, CMD_BLANK_CHECK};
    foreach (cmds[i]) begin
      op_fail_i <= (i < 2);
      run(PROM2_LO, cmds[i]);
      @(posedge ref_clk_i);
      #1 chk(cpu_stall_o, 1'b0);
      rc(REG_CTRL_A, 32'h1, 32'h0);
      wait_ready();
    end
    rc(REG_CTRL_A, 32'hc0, 32'hc0);
    rc(REG_ID_STAT, 32'h40, 32'h40);
    wr(REG_CMD, {24'h0, CMD_READ_STATUS});
    rc(REG_STATUS, 32'hb0, 32'hb0);
    op_fail_i <= 1'b0;
    wr(REG_CMD, {24'h0, CMD_CLEAR_STATUS});
    rc(REG_CTRL_A, 32'hc0, 32'h0);
    run(EXT_LO, CMD_PROGRAM);
    wait_ready();
    rc(REG_CTRL_A, 32'h40, 32'h40);
    wr(REG_CMD, {24'h0, CMD_CLEAR_STATUS});
    rc(4'hf, 32'hffffffff, 32'h0);
    $display("ram resident test done");
    // Mode select only after enable is set, and the port outputs hold while busy
    wr(REG_CTRL_D, 32'h1);
    wr(REG_CODE_BLK, {8'h00, PROM1_LO});
    port_i <= 8'h5a;
    run(PROM2_LO, CMD_PROGRAM);
    @(posedge ref_clk_i);
    port_i <= 8'ha5;
    #1 chk(cpu_stall_o, 1'b1);
    @(posedge ref_clk_i);
    #1 chk(port_o, 8'h5a);
    wait_ready();
    rc(REG_ID_STAT, 32'h20, 32'h20);
    wr(REG_CMD, {24'h0, CMD_READ_STATUS});
    rc(REG_STATUS, 32'hffffffff, 32'h0);
    run(PROM1_LO + 24'h000010, CMD_PROGRAM);
    wait_ready();
    rc(REG_CTRL_A, 32'h40, 32'h40);
    wr(REG_CTRL_A, 32'h0);
    wr(REG_PROC_MODE, 32'h0);
    four_mb_mode_i <= 1'b1;
    repeat (3) @(posedge ref_clk_i);
    #1 chk(ext_region_block_o, 1'b1);
    four_mb_mode_i <= 1'b0;
    repeat (3) @(posedge ref_clk_i);
    #1 chk(ext_region_block_o, 1'b0);
    $display("flash resident test done");
    tally_and_finish();
  end
endmodule : testbench

bind fsrc_ctrl fsrc_ctrl_asserts #(.PORT_W(PORT_W)) u_chk (.*);
